// ---- tid_pkg.sv ----
// Constants and types shared by both ends of the test access port link.
// Assumes both ends run on one system clock; the test clock is a sampled pin.
package tid_pkg;
    // ------------------------------------------------------------
    // Instruction codes, MSB on the left
    // ------------------------------------------------------------
    localparam int IR_W = 3;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_SAMPLE_Z = 3'h2;
    localparam logic [2:0] IR_RSVD_A = 3'h3;
    localparam logic [2:0] IR_SAMPLE = 3'h4;
    localparam logic [2:0] IR_PRIVATE = 3'h5;
    localparam logic [2:0] IR_RSVD_B = 3'h6;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE_VAL = 2'h1;
    // ------------------------------------------------------------
    // Register sizes and timing
    // ------------------------------------------------------------
    localparam int ID_W = 32;
    localparam int BSR_W_DEF = 8;
    localparam int RESET_TMS_ONES = 5;
    localparam int SYS_CLK_NS = 25;
    localparam int TCK_HALF_NS = 100;
    localparam int TCK_HALF_CYC = (TCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    // ------------------------------------------------------------
    // Port controller states (standard sequence)
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
        ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7,
        ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB,
        ST_EX1_IR = 4'hC, ST_PAU_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF
    } tid_state_t;
    // Next state from current state and sampled mode select
    function automatic tid_state_t tid_next(input tid_state_t s, input logic m);
        case (s)
            ST_RESET: tid_next = m ? ST_RESET : ST_IDLE;
            ST_IDLE: tid_next = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: tid_next = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tid_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: tid_next = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tid_next = m ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: tid_next = m ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: tid_next = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tid_next = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: tid_next = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: tid_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: tid_next = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tid_next = m ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: tid_next = m ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: tid_next = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tid_next = m ? ST_SEL_DR : ST_IDLE;
            default: tid_next = ST_RESET;
        endcase
    endfunction : tid_next
endpackage : tid_pkg

// ---- tid_link_if.sv ----
// Four-wire test link between the scan controller and the memory port.
// Assumes one clock/reset pair for both ends; no tri-state here.
`timescale 1ns/1ps
interface tid_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
    modport ctl (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface : tid_link_if

// ---- tid_dev.sv ----
// Memory-side test access port: controller, instruction and data registers.
// Assumes link pins are asynchronous; each passes two flip-flops first.
`timescale 1ns/1ps
module tid_dev
    import tid_pkg::*;
#(
    parameter int BSR_W = BSR_W_DEF,
    parameter logic [BSR_W-1:0] BSR_PIN_MASK = '1,
    parameter logic [BSR_W-1:0] BSR_DEFAULT = '1,
    parameter logic [ID_W-1:0] ID_VALUE = 32'h1234_5679 // Arbitrary code
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Link
    tid_link_if.dev link,
    // Memory pin ring and output control
    input wire logic [BSR_W-1:0] i_pins,
    output logic [BSR_W-1:0] o_bsr_par,
    output logic o_bsr_drive,
    output logic o_out_float,
    output logic [IR_W-1:0] o_instr
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] tck_s;
        logic [1:0] tms_s;
        logic [1:0] tdi_s;
        logic [BSR_W-1:0] pin_s0;
        logic [BSR_W-1:0] pin_s1;
        logic tck_prev;
        tid_state_t st;
        logic [IR_W-1:0] ir_sh;
        logic [IR_W-1:0] ir;
        logic byp;
        logic [ID_W-1:0] id_sh;
        logic [BSR_W-1:0] bsr;
        logic [BSR_W-1:0] bsr_par;
        logic drive;
        logic flt;
        logic tdo;
        logic tdo_oe;
    } tid_dev_t;
    tid_dev_t s_q, s_d;
    logic rise, fall;
    logic [IR_W-1:0] ir_eff;

    // Codes that put the boundary register between data in and out
    function automatic logic tid_sel_bsr(input logic [IR_W-1:0] code);
        return (code == IR_EXTEST) || (code == IR_SAMPLE) || (code == IR_SAMPLE_Z);
    endfunction : tid_sel_bsr

    // Next state on sampled test clock edges
    always_comb begin
        s_d = s_q;
        s_d.tck_s = {s_q.tck_s[0], link.tck};
        s_d.tms_s = {s_q.tms_s[0], link.tms};
        s_d.tdi_s = {s_q.tdi_s[0], link.tdi};
        // Memory pins come from another clock; two flops before capture
        s_d.pin_s0 = i_pins;
        s_d.pin_s1 = s_q.pin_s0;
        s_d.tck_prev = s_q.tck_s[1];
        rise = s_q.tck_s[1] & ~s_q.tck_prev;
        fall = ~s_q.tck_s[1] & s_q.tck_prev;
        ir_eff = s_q.ir;
        if (rise) begin
            // Rising edge: capture and shift, then advance
            case (s_q.st)
                ST_CAP_IR: s_d.ir_sh = {s_q.ir_sh[IR_W-1:2], IR_CAPTURE_VAL};
                ST_SH_IR: s_d.ir_sh = {s_q.tdi_s[1], s_q.ir_sh[IR_W-1:1]};
                ST_CAP_DR: begin
                    // Only the selected data register captures; the others hold
                    if (ir_eff == IR_IDCODE) begin
                        s_d.id_sh = ID_VALUE;
                    end else if (tid_sel_bsr(ir_eff)) begin
                        // Pins where bonded, defaults elsewhere
                        s_d.bsr = (s_q.pin_s1 & BSR_PIN_MASK)
                            | (BSR_DEFAULT & ~BSR_PIN_MASK);
                    end else begin
                        s_d.byp = 1'b0;
                    end
                end
                ST_SH_DR: begin
                    // Preload survives scans through the other registers
                    if (ir_eff == IR_IDCODE) begin
                        s_d.id_sh = {s_q.tdi_s[1], s_q.id_sh[ID_W-1:1]};
                    end else if (tid_sel_bsr(ir_eff)) begin
                        s_d.bsr = {s_q.tdi_s[1], s_q.bsr[BSR_W-1:1]};
                    end else begin
                        s_d.byp = s_q.tdi_s[1];
                    end
                end
                default: ;
            endcase
            s_d.st = tid_next(s_q.st, s_q.tms_s[1]);
        end
        if (fall) begin
            // Falling edge: update, output drive and data out
            case (s_q.st)
                ST_RESET: s_d.ir = IR_IDCODE;
                ST_UPD_IR: s_d.ir = s_q.ir_sh;
                default: ;
            endcase
            // Unselected data scans leave the parallel latch alone
            if (s_q.st == ST_UPD_IR || (s_q.st == ST_UPD_DR && tid_sel_bsr(s_q.ir)))
                s_d.bsr_par = s_q.bsr;
            // Drive only under external test; float only under sample-z
            s_d.drive = (s_d.ir == IR_EXTEST);
            s_d.flt = (s_d.ir == IR_SAMPLE_Z);
            s_d.tdo_oe = (s_q.st == ST_SH_IR || s_q.st == ST_SH_DR);
            if (s_q.st == ST_SH_IR)
                s_d.tdo = s_q.ir_sh[0];
            else begin
                case (s_q.ir)
                    IR_EXTEST, IR_SAMPLE, IR_SAMPLE_Z: s_d.tdo = s_q.bsr[0];
                    IR_IDCODE: s_d.tdo = s_q.id_sh[0];
                    default: s_d.tdo = s_q.byp;
                endcase
            end
        end
    end

    // Registers
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
            s_q.st <= ST_RESET;
            s_q.ir <= IR_IDCODE;
            s_q.ir_sh <= IR_IDCODE;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.tdo = s_q.tdo;
    assign link.tdo_oe = s_q.tdo_oe;
    assign o_bsr_par = s_q.bsr_par;
    assign o_bsr_drive = s_q.drive;
    assign o_out_float = s_q.flt;
    assign o_instr = s_q.ir;
endmodule : tid_dev

// ---- tid_ctl.sv ----
// Scan controller end: makes the test clock by a divider and runs one
// reset, instruction or data scan per request. Assumes requests from same clock.
`timescale 1ns/1ps
module tid_ctl
    import tid_pkg::*;
#(
    parameter int LEN_W = 8
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Request: op 0 = reset, 1 = instruction scan, 2 = data scan
    input wire logic i_req,
    input wire logic [1:0] i_op,
    input wire logic [LEN_W-1:0] i_len,
    input wire logic [63:0] i_wdata,
    output logic o_busy,
    output logic o_done,
    output logic [63:0] o_rdata,
    // Link
    tid_link_if.ctl link
);
    typedef enum logic [1:0] {C_IDLE = 2'h0, C_RUN = 2'h1, C_DONE = 2'h2} tid_cst_t;
    typedef struct packed {
        tid_cst_t st;
        logic [7:0] div;
        logic tck;
        logic tms;
        logic tdi;
        logic [1:0] tdo_s;
        logic [5:0] seq;
        logic [5:0] seq_len;
        logic [15:0] tms_pat;
        logic [LEN_W-1:0] cnt;
        logic [7:0] hd;
        logic [63:0] sh;
        logic [63:0] rd;
        logic done;
        logic busy;
    } tid_ctl_t;
    tid_ctl_t s_q, s_d;

    // Divider-timed walk: header TMS pattern, shift, exit to idle
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.tdo_s = {s_q.tdo_s[0], link.tdo};
        case (s_q.st)
            C_IDLE: begin
                s_d.tck = 1'b0;
                if (i_req) begin
                    s_d.st = C_RUN;
                    s_d.div = '0;
                    s_d.sh = i_wdata;
                    s_d.cnt = i_len;
                    s_d.seq = '0;
                    // Paths from idle: reset 11111, IR 1100, DR 100
                    case (i_op)
                        2'h0: begin
                            s_d.tms_pat = 16'h001F;
                            s_d.hd = 8'h05;
                        end
                        2'h1: begin
                            s_d.tms_pat = 16'h0003;
                            s_d.hd = 8'h04;
                        end
                        default: begin
                            s_d.tms_pat = 16'h0001;
                            s_d.hd = 8'h03;
                        end
                    endcase
                    s_d.seq_len = (i_op == 2'h0) ? 6'h05 : 6'h00;
                end
            end
            C_RUN: begin
                s_d.div = s_q.div + 8'h01;
                if (s_q.div == 8'(TCK_HALF_CYC - 1)) begin
                    s_d.div = '0;
                    s_d.tck = ~s_q.tck;
                    if (s_q.tck) begin
                        // Sample data out at the end of the high half: the round trip
                        // through both synchronisers is longer than half a period
                        if (s_q.hd == '0 && s_q.seq != '0 && s_q.seq_len == 6'h00)
                            s_d.rd = {s_q.tdo_s[1], s_q.rd[63:1]};
                        // Falling edge: set next TMS/TDI
                        if (s_q.hd != '0) begin
                            s_d.tms = s_q.tms_pat[0];
                            s_d.tms_pat = {1'b0, s_q.tms_pat[15:1]};
                            s_d.hd = s_q.hd - 8'h01;
                        end else if (s_q.seq_len == 6'h05) begin
                            s_d.tms = 1'b0;
                            s_d.st = C_DONE;
                        end else if (s_q.cnt != '0) begin
                            s_d.tdi = s_q.sh[0];
                            s_d.sh = {1'b0, s_q.sh[63:1]};
                            s_d.cnt = s_q.cnt - LEN_W'(1);
                            s_d.tms = (s_q.cnt == LEN_W'(1));
                            s_d.seq = 6'h01; // Flag only, so long scans never wrap it
                        end else begin
                            // Exit1 -> Update -> Idle; reserved codes passed through unchecked
                            s_d.tms = (s_q.seq_len == 6'h00);
                            s_d.seq_len = s_q.seq_len + 6'h01;
                            if (s_q.seq_len == 6'h01) s_d.st = C_DONE;
                        end
                    end
                end
            end
            C_DONE: begin
                s_d.done = 1'b1;
                s_d.st = C_IDLE;
            end
            default: s_d.st = C_IDLE;
        endcase
        // Busy kept as a flop so the output needs no decode
        s_d.busy = (s_d.st != C_IDLE);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
            s_q.st <= C_IDLE;
            s_q.tms <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.tck = s_q.tck;
    assign link.tms = s_q.tms;
    assign link.tdi = s_q.tdi;
    assign o_busy = s_q.busy;
    assign o_done = s_q.done;
    assign o_rdata = s_q.rd;
endmodule : tid_ctl

// ---- tid_link_sva.sv ----
// Assertions on the four-wire test link between the two ends.
// Assumes the link changes only on system clock edges; bench instantiates it.
`timescale 1ns/1ps
module tid_link_sva
    import tid_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // ------------------------------------------------------------
    // Shadow controller, stepped on sampled test clock rises
    // ------------------------------------------------------------
    tid_state_t st_q;
    logic tck_q;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= ST_RESET;
            tck_q <= 1'b0;
        end else begin
            tck_q <= tck;
            if (tck && !tck_q) begin
                st_q <= tid_next(st_q, tms);
            end
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    // Divider gives exact halves; low half may stretch between frames
    sequence hi_half_s;
        tck [*4] ##1 !tck;
    endsequence
    // First instruction bits out are 1 then 0, one test clock apart
    sequence ir_cap_s;
        tdo ##8 !tdo;
    endsequence
    tck_high_a: assert property ($rose(tck) |-> hi_half_s)
        else $error("test clock high half wrong");
    tck_low_a: assert property ($fell(tck) |-> !tck [*4])
        else $error("test clock low half short");
    tms_edge_a: assert property ($changed(tms) |-> !tck)
        else $error("mode select moved with clock high");
    tdi_edge_a: assert property ($changed(tdi) |-> !tck)
        else $error("data in moved with clock high");
    tdo_edge_a: assert property ($changed(tdo) && tdo_oe && $past(tdo_oe) |-> !$past(tck))
        else $error("data out moved off a falling edge");
    oe_rise_a: assert property ($rose(tdo_oe) |-> st_q inside {ST_SH_DR, ST_SH_IR})
        else $error("output enable outside shift");
    oe_fall_a: assert property ($fell(tdo_oe) |-> st_q inside {ST_EX1_DR, ST_EX1_IR})
        else $error("output enable dropped late");
    oe_idle_a: assert property (st_q == ST_IDLE |-> !tdo_oe)
        else $error("output enabled while idle");
    oe_reset_a: assert property (st_q == ST_RESET |-> !tdo_oe)
        else $error("output enabled in reset state");
    ir_capture_a: assert property ($rose(tdo_oe) && st_q == ST_SH_IR |-> ir_cap_s)
        else $error("instruction capture bits wrong");
endmodule : tid_link_sva

// ---- tap_instruction_decoder_tb.sv ----
// Bench: controller and device ends face each other over the link.
// Assumes package, interface, both ends and the link checker compiled first.
`timescale 1ns/1ps
module tap_instruction_decoder_tb;
    import tid_pkg::*;
    // ------------------------------------------------------------
    // Settings and signals
    // ------------------------------------------------------------
    localparam logic [31:0] ID_TB = 32'hC0DE_5A3B; // Arbitrary code
    localparam logic [7:0] MASK_TB = 8'hF0; // Low four cells unpinned
    localparam logic [7:0] DEF_TB = 8'hFF;
    localparam int DL = 40;
    logic i_sys_clk;
    logic i_nrst;
    logic i_req;
    logic [1:0] i_op;
    logic [7:0] i_len;
    logic [63:0] i_wdata;
    logic [63:0] o_rdata;
    logic o_busy;
    logic o_done;
    logic [7:0] i_pins;
    logic [7:0] o_bsr_par;
    logic o_bsr_drive;
    logic o_out_float;
    logic [2:0] o_instr;
    int fails;
    int tests_run;
    logic [31:0] seed;
    logic [7:0] exp_bsr;
    logic [2:0] codes [8] = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    tid_link_if tid_link_if_i ();
    tid_ctl tid_ctl_i (.i_sys_clk, .i_nrst, .i_req, .i_op, .i_len, .i_wdata, .o_busy,
        .o_done, .o_rdata, .link(tid_link_if_i));
    tid_dev #(.BSR_PIN_MASK(MASK_TB), .BSR_DEFAULT(DEF_TB), .ID_VALUE(ID_TB)) tid_dev_i (
        .i_sys_clk, .i_nrst, .link(tid_link_if_i), .i_pins, .o_bsr_par, .o_bsr_drive,
        .o_out_float, .o_instr);
    tid_link_sva tid_link_sva_i (.i_sys_clk, .i_nrst, .tck(tid_link_if_i.tck),
        .tms(tid_link_if_i.tms), .tdi(tid_link_if_i.tdi), .tdo(tid_link_if_i.tdo),
        .tdo_oe(tid_link_if_i.tdo_oe));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    // One scan; entered and left 2 ns after a clock edge
    task automatic scan(input logic [1:0] op, input logic [7:0] len, input logic [63:0] w);
        int n;
        i_op = op;
        i_len = len;
        i_wdata = w;
        i_req = 1'b1;
        @(posedge i_sys_clk);
        #2;
        i_req = 1'b0;
        chk("busy", 1'b1, o_busy);
        for (n = 0; n < 4000 && o_done !== 1'b1; n++) begin
            @(posedge i_sys_clk);
            #2;
        end
        if (n == 4000) begin
            fails++;
            final_report();
        end
        chk("busy at done", 1'b0, o_busy);
        // Device outputs trail the link by its synchroniser
        repeat (8) @(posedge i_sys_clk);
        #2;
    endtask : scan
    // ------------------------------------------------------------
    // Main sequence; reserved codes loaded on purpose to see them act
    // ------------------------------------------------------------
    initial begin
        int c;
        logic [63:0] w;
        logic [39:0] v;
        logic [7:0] cap;
        int i;
        logic bits [$];
        logic [39:0] ev;
        i_nrst = 1'b0;
        i_req = 1'b0;
        i_op = 2'h0;
        i_len = 8'h00;
        i_wdata = 64'h0;
        i_pins = 8'h00;
        fails = 0;
        tests_run = 0;
        exp_bsr = 8'h00;
        seed = 32'h4C09_A945;
        repeat (16) @(posedge i_sys_clk);
        #2;
        i_nrst = 1'b1;
        chk("instr at reset", IR_IDCODE, o_instr);
        // Controller idles with mode high; walk the port to reset first
        scan(2'h0, 8'h00, 64'h0);
        chk("instr after first reset", IR_IDCODE, o_instr);
        for (c = 0; c < 8; c++) begin
            scan(2'h1, 8'h03, 64'(codes[c]));
            chk("ir capture", 2'h1, o_rdata[62:61]);
            chk("instr", codes[c], o_instr);
            chk("drive", codes[c] == IR_EXTEST, o_bsr_drive);
            chk("float", codes[c] == IR_SAMPLE_Z, o_out_float);
            if (codes[c] == IR_EXTEST) begin
                chk("par at update", exp_bsr, o_bsr_par);
            end
            seed = xs(seed);
            i_pins = seed[7:0];
            w[31:0] = seed;
            seed = xs(seed);
            w[63:32] = seed;
            scan(2'h2, 8'(DL), w);
            v = o_rdata[63:24];
            cap = (i_pins & MASK_TB) | (DEF_TB & ~MASK_TB);
            // Model: selected register as a bit queue, first out at the front
            bits = {};
            case (codes[c])
                IR_EXTEST, IR_SAMPLE_Z, IR_SAMPLE: begin
                    for (i = 0; i < 8; i++) begin
                        bits.push_back(cap[i]);
                    end
                end
                IR_IDCODE: begin
                    for (i = 0; i < 32; i++) begin
                        bits.push_back(ID_TB[i]);
                    end
                end
                default: begin
                    bits.push_back(1'b0);
                end
            endcase
            for (i = 0; i < DL; i++) begin
                ev[i] = bits.pop_front();
                bits.push_back(w[i]);
            end
            case (codes[c])
                IR_EXTEST, IR_SAMPLE_Z, IR_SAMPLE: begin
                    chk("boundary out", ev, v);
                    for (i = 0; i < 8; i++) begin
                        exp_bsr[i] = bits[i];
                    end
                end
                IR_IDCODE: begin
                    chk("id out", ev, v);
                end
                default: begin
                    chk("bypass out", ev, v);
                end
            endcase
            chk("par", exp_bsr, o_bsr_par);
        end
        scan(2'h0, 8'h00, 64'h0);
        chk("instr after reset", IR_IDCODE, o_instr);
        final_report();
    end
endmodule : tap_instruction_decoder_tb
